// File: shared/pxb_defs.svh
// Constants for the port and external bus pin block
`ifndef PXB_DEFS_SVH
`define PXB_DEFS_SVH
`define PXB_PORT_RST 8'hFF
`define PXB_STRONG_NS 10
`define PXB_STRONG_CYC ((`PXB_STRONG_NS + 4) / 5)
`define PXB_T2_BIT 0
`define PXB_TIMER2_CAPTURE_RELOAD_TRIGGER_BIT 1
`endif

// File: shared/pxb_pkg.sv
// Types for the port and external bus pin block
package pxb_pkg;
  // Bus cycle phases, one-hot
  typedef enum logic [4:0] {
    PXB_IDLE = 5'h01,
    PXB_ADDR = 5'h02,
    PXB_TURN = 5'h04,
    PXB_DATA = 5'h08,
    PXB_DONE = 5'h10
  } pxb_state_t;
  // One external access request from the core
  typedef struct packed {
    logic valid;
    logic is_data;
    logic is_write;
    logic use_ptr8;
    logic [15:0] addr;
    logic [7:0] wdata;
  } pxb_req_t;
endpackage

// File: hw/pxb_pins.sv
// Pin logic for ports zero, one, two and the address latch strobe
`timescale 1ns/10ps
`include "pxb_defs.svh"
module pxb_pins (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire pxb_pkg::pxb_req_t REQ_I,
  output logic BUSY_O,
  output logic DONE_O,
  output logic [7:0] RDATA_O,
  input wire logic P1_WR_I,
  input wire logic [7:0] P1_WDATA_I,
  input wire logic P2_WR_I,
  input wire logic [7:0] P2_WDATA_I,
  output logic [7:0] P1_LATCH_O,
  output logic [7:0] P2_LATCH_O,
  output logic [7:0] PORT_ONE_PINS_RD_O,
  output logic TIMER2_EXT_IO_O,
  output logic TIMER2_CAPTURE_RELOAD_TRIGGER_O,
  output logic EXT_IRQ_TWO_RISING_O,
  output logic EXT_IRQ_THREE_FALLING_O,
  output logic EXT_IRQ_FOUR_RISING_O,
  output logic EXT_IRQ_FIVE_FALLING_O,
  output logic ADDR_LATCH_STROBE_O,
  output logic PROGRAM_FETCH_STROBE_N_O,
  output logic DATA_WR_STROBE_N_O,
  output logic DATA_RD_STROBE_N_O,
  input wire logic [7:0] PORT_ZERO_I,
  output logic [7:0] PORT_ZERO_O,
  output logic [7:0] PORT_ZERO_OE_N_O,
  output logic [7:0] PORT_TWO_O,
  input wire logic [7:0] PORT_ONE_PINS_I,
  output logic [7:0] PORT_ONE_PD_OE_N_O,
  output logic [7:0] PORT_ONE_STRONG_UP_OE_N_O
);
  // ----------------------------------------------------------------
  // Bus cycle sequencer
  // ----------------------------------------------------------------
  pxb_pkg::pxb_state_t st_r, st_nxt; // Phase of access
  pxb_pkg::pxb_req_t req_r, req_nxt; // Captured request
  logic [7:0] p0o_r, p0o_nxt; // Port zero drive value
  logic [7:0] p0oe_r, p0oe_nxt; // Port zero enables, low drives
  logic [7:0] p2_r, p2_nxt; // Port two pins
  logic [7:0] rd_r, rd_nxt; // Read data
  logic ale_r, ale_nxt; // Latch strobe
  logic program_fetch_strobe_n_r, program_fetch_strobe_n_nxt; // Fetch strobe, low active
  logic wr_r, wr_nxt; // Write strobe, low active
  logic rdn_r, rdn_nxt; // Read strobe, low active
  logic done_r, done_nxt; // Completion pulse
  logic [7:0] p2l_r, p2l_nxt; // Port two software latch

  // Next-state for bus sequencing
  always_comb begin
    st_nxt = st_r;
    req_nxt = req_r;
    p0o_nxt = p0o_r;
    p0oe_nxt = p0oe_r;
    p2_nxt = p2_r;
    rd_nxt = rd_r;
    ale_nxt = ale_r;
    program_fetch_strobe_n_nxt = program_fetch_strobe_n_r;
    wr_nxt = wr_r;
    rdn_nxt = rdn_r;
    done_nxt = 1'b0;
    p2l_nxt = P2_WR_I ? P2_WDATA_I : p2l_r;
    unique case (st_r)
      pxb_pkg::PXB_IDLE: begin
        if (REQ_I.valid) begin
          req_nxt = REQ_I;
          st_nxt = pxb_pkg::PXB_ADDR;
          ale_nxt = 1'b1;
          p0o_nxt = REQ_I.addr[7:0];
          p0oe_nxt = 8'h00;
          // Pointer moves use the software latch as high byte
          p2_nxt = (REQ_I.is_data && REQ_I.use_ptr8) ? p2l_r : REQ_I.addr[15:8];
        end
      end
      pxb_pkg::PXB_ADDR: begin
        ale_nxt = 1'b0;
        st_nxt = pxb_pkg::PXB_TURN;
        if (req_r.is_data && req_r.is_write) begin
          p0o_nxt = req_r.wdata;
          wr_nxt = 1'b0;
        end else begin
          p0oe_nxt = 8'hFF;
          if (req_r.is_data) begin
            rdn_nxt = 1'b0;
          end else begin
            program_fetch_strobe_n_nxt = 1'b0;
          end
        end
      end
      pxb_pkg::PXB_TURN: begin
        // Bus released two full cycles before sampling
        st_nxt = pxb_pkg::PXB_DATA;
      end
      pxb_pkg::PXB_DATA: begin
        if (!(req_r.is_data && req_r.is_write)) begin
          rd_nxt = PORT_ZERO_I;
        end
        program_fetch_strobe_n_nxt = 1'b1;
        wr_nxt = 1'b1;
        rdn_nxt = 1'b1;
        st_nxt = pxb_pkg::PXB_DONE;
      end
      pxb_pkg::PXB_DONE: begin
        // Park: port zero floats high, ready for next
        p0oe_nxt = 8'hFF;
        p0o_nxt = 8'hFF;
        ale_nxt = 1'b1;
        done_nxt = 1'b1;
        st_nxt = pxb_pkg::PXB_IDLE;
      end
      default: begin
        st_nxt = pxb_pkg::PXB_IDLE;
      end
    endcase
  end

  // Register bus state
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      st_r <= pxb_pkg::PXB_IDLE;
      req_r <= '0;
      p0o_r <= `PXB_PORT_RST;
      p0oe_r <= 8'hFF;
      p2_r <= `PXB_PORT_RST;
      rd_r <= 8'h00;
      ale_r <= 1'b1;
      program_fetch_strobe_n_r <= 1'b1;
      wr_r <= 1'b1;
      rdn_r <= 1'b1;
      done_r <= 1'b0;
      p2l_r <= `PXB_PORT_RST;
    end else begin
      st_r <= st_nxt;
      req_r <= req_nxt;
      p0o_r <= p0o_nxt;
      p0oe_r <= p0oe_nxt;
      p2_r <= p2_nxt;
      rd_r <= rd_nxt;
      ale_r <= ale_nxt;
      program_fetch_strobe_n_r <= program_fetch_strobe_n_nxt;
      wr_r <= wr_nxt;
      rdn_r <= rdn_nxt;
      done_r <= done_nxt;
      p2l_r <= p2l_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Port one quasi-bidirectional drivers
  // ----------------------------------------------------------------
  logic [7:0] p1l_r, p1l_nxt; // Port one latch
  logic [7:0] p1in_r, p1in_nxt; // Sampled pin levels
  logic [1:0] sc_r [8]; // Strong pull-up counters
  logic [1:0] sc_nxt [8];

  // Latch, pin sample and transition driver timing
  always_comb begin
    p1l_nxt = P1_WR_I ? P1_WDATA_I : p1l_r;
    p1in_nxt = PORT_ONE_PINS_I;
    for (int i = 0; i < 8; i++) begin
      if (P1_WR_I && P1_WDATA_I[i] && !p1l_r[i]) begin
        sc_nxt[i] = 2'(`PXB_STRONG_CYC);
      end else if (sc_r[i] != 2'h0) begin
        sc_nxt[i] = sc_r[i] - 2'h1;
      end else begin
        sc_nxt[i] = 2'h0;
      end
    end
  end

  // Register port one state
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      p1l_r <= `PXB_PORT_RST;
      p1in_r <= `PXB_PORT_RST;
      for (int i = 0; i < 8; i++) begin
        sc_r[i] <= 2'h0;
      end
    end else begin
      p1l_r <= p1l_nxt;
      p1in_r <= p1in_nxt;
      for (int i = 0; i < 8; i++) begin
        sc_r[i] <= sc_nxt[i];
      end
    end
  end

  // Edge detect on sampled pins; first stage is a plain register
  logic [7:0] p1d_r; // Delayed sample
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      p1d_r <= `PXB_PORT_RST;
    end else begin
      p1d_r <= p1in_r;
    end
  end

  // Output assignments
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      PORT_ONE_STRONG_UP_OE_N_O[i] = (sc_r[i] == 2'h0);
    end
  end
  assign PORT_ONE_PD_OE_N_O = p1l_r;
  assign PORT_ONE_PINS_RD_O = p1in_r;
  assign P1_LATCH_O = p1l_r;
  assign P2_LATCH_O = p2l_r;
  assign TIMER2_EXT_IO_O = p1in_r[`PXB_T2_BIT];
  assign TIMER2_CAPTURE_RELOAD_TRIGGER_O = p1in_r[`PXB_TIMER2_CAPTURE_RELOAD_TRIGGER_BIT];
  assign EXT_IRQ_TWO_RISING_O = p1in_r[4] & ~p1d_r[4];
  assign EXT_IRQ_THREE_FALLING_O = ~p1in_r[5] & p1d_r[5];
  assign EXT_IRQ_FOUR_RISING_O = p1in_r[6] & ~p1d_r[6];
  assign EXT_IRQ_FIVE_FALLING_O = ~p1in_r[7] & p1d_r[7];
  assign ADDR_LATCH_STROBE_O = ale_r;
  assign PROGRAM_FETCH_STROBE_N_O = program_fetch_strobe_n_r;
  assign DATA_WR_STROBE_N_O = wr_r;
  assign DATA_RD_STROBE_N_O = rdn_r;
  assign PORT_ZERO_O = p0o_r;
  assign PORT_ZERO_OE_N_O = p0oe_r;
  assign PORT_TWO_O = p2_r;
  assign RDATA_O = rd_r;
  assign DONE_O = done_r;
  assign BUSY_O = (st_r != pxb_pkg::PXB_IDLE);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_ale_rst;
    @(posedge CORE_CLK_I) !RST_N_I |=> ADDR_LATCH_STROBE_O && PORT_ZERO_OE_N_O == 8'hFF && PROGRAM_FETCH_STROBE_N_O;
  endproperty
  a_ale_rst: assert property (p_ale_rst) else $error("reset levels wrong");
  property p_addr_out;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (st_r == pxb_pkg::PXB_IDLE && REQ_I.valid) |=> ADDR_LATCH_STROBE_O && PORT_ZERO_O == $past(REQ_I.addr[7:0])
      && PORT_ZERO_OE_N_O == 8'h00;
  endproperty
  a_addr_out: assert property (p_addr_out) else $error("address not presented");
  property p_ale_fall;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I) (st_r == pxb_pkg::PXB_ADDR) |=> !ADDR_LATCH_STROBE_O [*3];
  endproperty
  a_ale_fall: assert property (p_ale_fall) else $error("strobe did not fall");
  property p_release;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (st_r == pxb_pkg::PXB_DATA && !(req_r.is_data && req_r.is_write)) |-> PORT_ZERO_OE_N_O == 8'hFF;
  endproperty
  a_release: assert property (p_release) else $error("bus driven while reading");
  property p_pd;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I) P1_WR_I && !P1_WDATA_I[0] |=> !PORT_ONE_PD_OE_N_O[0];
  endproperty
  a_pd: assert property (p_pd) else $error("pull-down missing");
  property p_strong;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      P1_WR_I && P1_WDATA_I[3] && !P1_LATCH_O[3] |=> !PORT_ONE_STRONG_UP_OE_N_O[3] ##2 PORT_ONE_STRONG_UP_OE_N_O[3];
  endproperty
  a_strong: assert property (p_strong) else $error("transition driver timing");
  property p_irq;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I) $rose(p1in_r[4]) |-> EXT_IRQ_TWO_RISING_O;
  endproperty
  a_irq: assert property (p_irq) else $error("rising edge missed");
  property p_ptr;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (st_r == pxb_pkg::PXB_IDLE && REQ_I.valid && REQ_I.is_data && REQ_I.use_ptr8) |=> PORT_TWO_O == $past(p2l_r);
  endproperty
  a_ptr: assert property (p_ptr) else $error("latch not used as high byte");
  property p_program_fetch_strobe_n;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I) req_r.is_data && BUSY_O |-> PROGRAM_FETCH_STROBE_N_O;
  endproperty
  a_program_fetch_strobe_n: assert property (p_program_fetch_strobe_n) else $error("fetch strobe during data");
endmodule

// File: dv/pxb_ext_mem.sv
// External memory and transparent address latch facing the bus pins
`timescale 1ns/10ps
module pxb_ext_mem (
  input wire logic strobe_i,
  input wire logic fetch_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [7:0] bus_i,
  input wire logic [7:0] high_i,
  output logic [7:0] bus_o,
  output logic [7:0] lat_o
);
  logic [7:0] mem [logic [15:0]]; // Sparse store
  logic [7:0] last = 8'h00; // Last driven value
  wire [7:0] bus_dly; // Pins as the latch sees them, a moment late
  // Models the latch hold time: the strobe falls on the same edge that changes the bus
  assign #1 bus_dly = bus_i;
  // ---------------------------------------------
  // Latch and memory
  // ---------------------------------------------
  // Latch is open while the strobe is high
  always @* begin
    if (strobe_i) lat_o = bus_dly;
  end
  // Unwritten cells answer a pattern so stale data cannot pass
  always @* begin
    if (!strobe_i && (!rd_n_i || !fetch_n_i)) begin
      bus_o = mem.exists({high_i, lat_o}) ? mem[{high_i, lat_o}] : lat_o ^ high_i;
    end else begin
      bus_o = ~last; // Released bus shows no old value
    end
  end
  // Remember the read value to invert it after release
  always @(posedge rd_n_i or posedge fetch_n_i) last = bus_o;
  // Write lands as the write strobe rises
  always @(posedge wr_n_i) begin
    if (!strobe_i) mem[{high_i, lat_o}] = bus_i;
  end
endmodule

// File: dv/pxb_pins_bench.sv
// Self-checking bench for the port and bus pin block
`timescale 1ns/10ps
module pxb_pins_bench;
  logic clk = 1'b0, rst_n = 1'b0, p1_wr = 1'b0, p2_wr = 1'b0;
  logic [7:0] p1_wd = 8'hFF, p2_wd = 8'hFF, p1_ext = 8'hFF, p2_val = 8'hFF, wd, mem_bus, lat, hi_cap, lo_cap;
  logic [7:0] p0_o, oe_n, pd_n, up_n, p2_pins, rdata, p1_rd, p1_lat, p2_lat;
  logic [15:0] a;
  logic [24:0] e;
  logic [5:0] alt; // Timer pins then interrupt pulses
  logic busy, done, ale, program_fetch_strobe_n_n, wr_n, rd_n;
  pxb_pkg::pxb_req_t req = '0;
  logic [7:0] model [logic [15:0]]; // Expected memory
  logic [24:0] expq [$]; // Read flag, address, data
  int bad_count = 0, samples_checked = 0, seed = 32'h96936a3a, up_cnt = 0, n;
  int irq_cnt [6] = '{default: 0};
  wire [7:0] p0_wire = (~oe_n & p0_o) | (oe_n & mem_bus);
  wire [7:0] p1_wire = p1_ext & pd_n; // Strong pull-down beats outside drive
  pxb_pins u_dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .REQ_I(req), .BUSY_O(busy), .DONE_O(done),
    .RDATA_O(rdata), .P1_WR_I(p1_wr), .P1_WDATA_I(p1_wd), .P2_WR_I(p2_wr), .P2_WDATA_I(p2_wd),
    .P1_LATCH_O(p1_lat), .P2_LATCH_O(p2_lat), .PORT_ONE_PINS_RD_O(p1_rd), .TIMER2_EXT_IO_O(alt[0]),
    .TIMER2_CAPTURE_RELOAD_TRIGGER_O(alt[1]), .EXT_IRQ_TWO_RISING_O(alt[2]),
    .EXT_IRQ_THREE_FALLING_O(alt[3]), .EXT_IRQ_FOUR_RISING_O(alt[4]), .EXT_IRQ_FIVE_FALLING_O(alt[5]),
    .ADDR_LATCH_STROBE_O(ale), .PROGRAM_FETCH_STROBE_N_O(program_fetch_strobe_n_n), .DATA_WR_STROBE_N_O(wr_n),
    .DATA_RD_STROBE_N_O(rd_n), .PORT_ZERO_I(p0_wire), .PORT_ZERO_O(p0_o), .PORT_ZERO_OE_N_O(oe_n),
    .PORT_TWO_O(p2_pins), .PORT_ONE_PINS_I(p1_wire), .PORT_ONE_PD_OE_N_O(pd_n),
    .PORT_ONE_STRONG_UP_OE_N_O(up_n));
  pxb_ext_mem u_mem (.strobe_i(ale), .fetch_n_i(program_fetch_strobe_n_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .bus_i(p0_wire), .high_i(p2_pins), .bus_o(mem_bus), .lat_o(lat));
  // ---------------------------------------------
  // Shared tasks
  // ---------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Inputs always move 1 ns after an edge
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Notes the expectation, waits until the block is idle, then presents the request for one cycle
  task automatic access(input logic d, w, p, input logic [15:0] ad, input logic [7:0] dt);
    logic [15:0] ea;
    int k;
    ea = (d && p) ? {p2_val, ad[7:0]} : ad;
    if (w) model[ea] = dt;
    expq.push_back({!w, ea, model.exists(ea) ? model[ea] : ea[7:0] ^ ea[15:8]});
    k = 0;
    while (busy !== 1'b0 && k < 20) begin
      tick(1);
      k++;
    end
    req = '{1'b1, d, w, p, ad, dt};
    tick(1);
    req.valid = 1'b0;
  endtask
  task automatic p1_write(input logic [7:0] v);
    p1_wd = v;
    p1_wr = 1'b1;
    tick(1);
    p1_wr = 1'b0;
  endtask
  // ---------------------------------------------
  // Watchers
  // ---------------------------------------------
  initial forever #2.5 clk = ~clk;
  // Both address bytes are taken as the strobe falls; the latch reopens when the bus parks
  always @(negedge ale) begin
    hi_cap = p2_pins;
    lo_cap = lat;
  end
  // Counts pulses and compares each finished access with its note
  always @(posedge clk) begin
    if (up_n[0] === 1'b0) up_cnt++;
    for (int i = 0; i < 6; i++) if (alt[i] === 1'b1) irq_cnt[i]++;
    #1;
    if (done === 1'b1 && expq.size() > 0) begin
      e = expq.pop_front();
      check(lo_cap, e[15:8]);
      check(hi_cap, e[23:16]);
      if (e[24]) check(rdata, e[7:0]);
    end
  end
  // Run should end far earlier, so a hang is cut short here
  initial begin
    #100000;
    bad_count++;
    give_verdict();
  end
  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    tick(6);
    check({ale, program_fetch_strobe_n_n, wr_n, rd_n, oe_n}, 16'h0FFF);
    check({p0_o, pd_n}, 16'hFFFF);
    check({p1_lat, p2_pins}, 16'hFFFF);
    rst_n = 1'b1;
    p2_val = 8'($random(seed));
    p2_wd = p2_val;
    p2_wr = 1'b1;
    tick(1);
    p2_wr = 1'b0;
    tick(1);
    check(p2_lat, p2_val);
    for (int i = 0; i < 8; i++) begin
      a = 16'($random(seed));
      wd = 8'($random(seed));
      access(1'b1, 1'b1, i[0], a, wd);
      access(1'b1, 1'b0, i[0], a, 8'h00);
      access(1'b0, 1'b0, 1'b0, a, 8'h00);
    end
    tick(8);
    check(16'(expq.size()), 16'h0000);
    $display("bus test done");
    p1_write(8'h00);
    tick(2);
    check({pd_n, p1_rd}, 16'h0000);
    n = up_cnt;
    p1_write(8'hFF);
    tick(6);
    check(16'(up_cnt - n), 16'h0002);
    check(pd_n, 8'hFF);
    p1_ext = 8'($random(seed));
    tick(3);
    check({p1_rd, 6'h00, alt[1:0]}, {p1_ext, 6'h00, p1_ext[1:0]});
    $display("port one test done");
    for (int k = 0; k < 4; k++) begin
      p1_ext = 8'h00;
      tick(4);
      n = irq_cnt[k + 2];
      p1_ext[k + 4] = 1'b1;
      tick(4);
      check(16'(irq_cnt[k + 2] - n), k[0] ? 16'h0000 : 16'h0001);
      p1_ext = 8'h00;
      tick(4);
      check(16'(irq_cnt[k + 2] - n), 16'h0001);
    end
    $display("interrupt test done");
    give_verdict();
  end
endmodule
